// file: include/std_pkg.sv
// package: register map, field positions and carrier types for the supply threshold detector
package std_pkg;
   // register byte offsets
   localparam logic [15:0] STD_REG_CTRL = 16'h2310;
   localparam logic [15:0] STD_ALIAS_CLR = 16'h0004;
   localparam logic [15:0] STD_ALIAS_SET = 16'h0008;
   localparam logic [15:0] STD_ALIAS_INV = 16'h000c;
   // field positions
   localparam int STD_BIT_ON = 15;
   localparam int STD_BIT_IDLE = 13;
   localparam int STD_BIT_DIR = 11;
   localparam int STD_BIT_BGS = 10;
   localparam int STD_BIT_RFS = 9;
   localparam int STD_BIT_EVT = 8;
   localparam int STD_LVL_LSB = 0;
   localparam int STD_LVL_W = 4;
   // writable mask and reset value
   localparam logic [31:0] STD_WR_MASK = 32'h0000_a80f;
   localparam logic [31:0] STD_CTRL_RST = 32'h0000_0000;
   localparam logic [3:0] STD_LVL_EXT = 4'hf;
   localparam logic [3:0] STD_LVL_RST = 4'h0;
   // write operation decoded from the alias offset
   typedef enum logic [1:0] {
      STD_OP_WR = 2'h0,
      STD_OP_CLR = 2'h1,
      STD_OP_SET = 2'h2,
      STD_OP_INV = 2'h3
   } std_op_t;
   // analog status as seen from the comparator side
   typedef struct packed {
      logic cmp_above;
      logic bg_stable;
      logic ref_stable;
   } std_ana_t;
   // control word handed to the analog side
   typedef struct packed {
      logic enable;
      logic ext_sel;
      logic [3:0] level;
   } std_ctl_t;
endpackage

// file: rtl/std_sync.sv
// two-stage synchroniser for the analog status levels
`timescale 1ns/100ps
module std_sync
#(
   parameter int W = 3
)
(
   // clock, reset and enable
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic ce,
   // levels
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;

   // first stage only feeds the second
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         s1_q <= '0;
         s2_q <= '0;
      end
      else if (ce)
      begin
         s1_q <= din;
         s2_q <= s1_q;
      end
   end

   assign dout = s2_q;
endmodule

// file: rtl/std_top.sv
// supply threshold detector control: register, synchronisers and event logic
`timescale 1ns/100ps
//
// Behaviour
// [R1] bit 15 enables the detector, and while it is clear no event or interrupt flag is made.
// [R2] bit 13 set halts the detector while the device is idle, clear keeps it running.
// [R3] bit 11 set makes an event when the supply reaches or rises above the trip, clear when it falls below.
// [R4] bit 10 reads the synchronised band-gap stable level and ignores writes.
// [R5] bit 9 reads the synchronised reference stable level and while low no interrupt flag is made.
// [R6] software should not enable the interrupt while the reference stable flag reads zero.
// [R7] bit 8 reads one while a detection event is active and zero otherwise.
// [R8] a crossing of the trip in the selected direction pulses the interrupt flag output.
// [R9] trip code 1111 selects the external sense input compared with the band-gap reference.
// [R10] trip codes 1110 down to 0101 pass unchanged to the analog reference selector.
// [R11] software must not program the reserved trip codes 0000 to 0100.
// [R12] bits 31 to 16, 14, 12 and 7 to 4 read zero and ignore writes.
// [R13] all implemented bits reset to zero.
// [R14] aliases at +0x4, +0x8 and +0xc clear, set and invert the written one bits.
// [R15] idle keeps the clocks running, so the detector works in idle unless bit 13 is set.
// [R16] comparator and stability levels pass a two-stage synchroniser before use.
module std_top
(
   // clock, reset, enable
   input wire logic CLK,
   input wire logic SYS_RST,
   input wire logic CE,
   // avalon-mm slave
   input wire logic [15:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // system state
   input wire logic IDLE_MODE,
   // analog side
   input wire std_pkg::std_ana_t ANA_IN,
   output std_pkg::std_ctl_t ANA_CTL,
   // interrupt flag pulse to the interrupt controller
   output logic DETECT_IRQ
);
   logic [31:0] ctrl_q;
   logic [31:0] ctrl_d;
   logic [2:0] sync_out;
   logic cmp_s;
   logic bg_s;
   logic rf_s;
   logic running;
   logic event_now;
   logic evt_q;
   logic irq_q;
   logic ack_q;
   logic hit;
   logic [31:0] rd_word;
   logic [31:0] be_mask;
   std_pkg::std_ctl_t ctl_q;

   // decode offset into the write operation, or flag an unmapped address
   function automatic std_pkg::std_op_t op_of(input logic [15:0] a);
      logic [15:0] d;
      d = a - std_pkg::STD_REG_CTRL;
      case (d)
         std_pkg::STD_ALIAS_CLR: op_of = std_pkg::STD_OP_CLR;
         std_pkg::STD_ALIAS_SET: op_of = std_pkg::STD_OP_SET;
         std_pkg::STD_ALIAS_INV: op_of = std_pkg::STD_OP_INV;
         default: op_of = std_pkg::STD_OP_WR;
      endcase
   endfunction

   function automatic logic is_hit(input logic [15:0] a);
      logic [15:0] d;
      d = a - std_pkg::STD_REG_CTRL;
      is_hit = (d == 16'h0000) || (d == std_pkg::STD_ALIAS_CLR)
         || (d == std_pkg::STD_ALIAS_SET) || (d == std_pkg::STD_ALIAS_INV);
   endfunction

   std_sync #(.W(3)) u_sync
   (
      .CLK(CLK),
      .SYS_RST(SYS_RST),
      .ce(CE),
      .din({ANA_IN.cmp_above, ANA_IN.bg_stable, ANA_IN.ref_stable}),
      .dout(sync_out)
   ); // [R16]

   assign cmp_s = sync_out[2];
   assign bg_s = sync_out[1];
   assign rf_s = sync_out[0];

   assign hit = is_hit(AVS_ADDRESS);
   assign be_mask = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
      {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

   // alias operations touch only writable bits selected by byte enables
   always_comb
   begin
      logic [31:0] m;
      m = std_pkg::STD_WR_MASK & be_mask;
      ctrl_d = ctrl_q;
      case (op_of(AVS_ADDRESS))
         std_pkg::STD_OP_CLR: ctrl_d = ctrl_q & ~(AVS_WRITEDATA & m); // [R14]
         std_pkg::STD_OP_SET: ctrl_d = ctrl_q | (AVS_WRITEDATA & m); // [R14]
         std_pkg::STD_OP_INV: ctrl_d = ctrl_q ^ (AVS_WRITEDATA & m); // [R14]
         std_pkg::STD_OP_WR: ctrl_d = (ctrl_q & ~m) | (AVS_WRITEDATA & m);
         default: ctrl_d = ctrl_q;
      endcase
      ctrl_d = ctrl_d & std_pkg::STD_WR_MASK; // [R12]
   end

   // one-cycle wait state: request accepted on the edge where waitrequest is low
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         ack_q <= 1'b0;
      else if (CE)
         ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         AVS_WAITREQUEST <= 1'b1;
      else if (CE)
         AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_q);
   end

   // control register
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         ctrl_q <= std_pkg::STD_CTRL_RST; // [R13]
      else if (CE && AVS_WRITE && !AVS_WAITREQUEST && hit)
         ctrl_q <= ctrl_d;
   end

   // read word: status bits from hardware, reserved bits zero
   always_comb
   begin
      rd_word = ctrl_q & std_pkg::STD_WR_MASK; // [R12]
      rd_word[std_pkg::STD_BIT_BGS] = bg_s; // [R4]
      rd_word[std_pkg::STD_BIT_RFS] = rf_s; // [R5]
      rd_word[std_pkg::STD_BIT_EVT] = evt_q; // [R7]
   end

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         AVS_READDATA <= 32'h0000_0000;
      else if (CE && AVS_READ && AVS_WAITREQUEST && !ack_q)
         AVS_READDATA <= hit ? rd_word : 32'h0000_0000;
   end

   // idle clocks run on; besides a clear bit 15, only the idle halt bit stops the detector
   assign running = ctrl_q[std_pkg::STD_BIT_ON]
      && !(IDLE_MODE && ctrl_q[std_pkg::STD_BIT_IDLE]); // [R1] [R2] [R15]

   // comparator output is high when the sensed level is at or above the trip
   assign event_now = running && (ctrl_q[std_pkg::STD_BIT_DIR] ? cmp_s : !cmp_s); // [R3]

   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         evt_q <= 1'b0;
      else if (CE)
         evt_q <= event_now; // [R7]
   end

   // interrupt flag on entry into the event, gated by reference stability
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
         irq_q <= 1'b0;
      else if (CE)
         irq_q <= event_now && !evt_q && rf_s; // [R8] [R5] [R1]
   end

   assign DETECT_IRQ = irq_q;

   // analog control word, code forwarded unchanged
   always_ff @(posedge CLK)
   begin
      if (SYS_RST)
      begin
         ctl_q.enable <= 1'b0;
         ctl_q.ext_sel <= 1'b0;
         ctl_q.level <= std_pkg::STD_LVL_RST;
      end
      else if (CE)
      begin
         ctl_q.enable <= running;
         ctl_q.level <= ctrl_q[std_pkg::STD_LVL_LSB +: std_pkg::STD_LVL_W]; // [R10]
         ctl_q.ext_sel <= ctrl_q[std_pkg::STD_LVL_LSB +: std_pkg::STD_LVL_W]
            == std_pkg::STD_LVL_EXT; // [R9]
      end
   end

   assign ANA_CTL = ctl_q;

   // checks
   // status bits are readable though not writable
   localparam logic [31:0] RD_MASK = std_pkg::STD_WR_MASK
      | (32'h0000_0001 << std_pkg::STD_BIT_BGS) | (32'h0000_0001 << std_pkg::STD_BIT_RFS)
      | (32'h0000_0001 << std_pkg::STD_BIT_EVT);

   sequence enter_evt_s;
      event_now && !evt_q && rf_s && CE;
   endsequence

   sequence req_seen_s;
      CE && (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && !ack_q;
   endsequence

   sequence bus_take_s;
      CE && (AVS_READ || AVS_WRITE) && !AVS_WAITREQUEST;
   endsequence

   sequence rd_load_s;
      CE && AVS_READ && AVS_WAITREQUEST && !ack_q;
   endsequence

   wait_one_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R14]
      req_seen_s |=> !AVS_WAITREQUEST)
      else $error("waitrequest did not drop after request");

   wait_back_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R14]
      bus_take_s |=> AVS_WAITREQUEST)
      else $error("waitrequest low for more than one cycle");

   set_alias_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R14]
      CE && AVS_WRITE && !AVS_WAITREQUEST && hit && op_of(AVS_ADDRESS) == std_pkg::STD_OP_SET
      && AVS_WRITEDATA[std_pkg::STD_BIT_ON] && AVS_BYTEENABLE[1] |=> ctrl_q[std_pkg::STD_BIT_ON])
      else $error("set alias failed");

   inv_alias_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R14]
      CE && AVS_WRITE && !AVS_WAITREQUEST && hit && op_of(AVS_ADDRESS) == std_pkg::STD_OP_INV
      && AVS_WRITEDATA[std_pkg::STD_BIT_DIR] && AVS_BYTEENABLE[1]
      |=> ctrl_q[std_pkg::STD_BIT_DIR] != $past(ctrl_q[std_pkg::STD_BIT_DIR]))
      else $error("invert alias failed");

   wr_land_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R12]
      CE && AVS_WRITE && !AVS_WAITREQUEST && hit && op_of(AVS_ADDRESS) == std_pkg::STD_OP_WR
      && AVS_BYTEENABLE == 4'hf |=> ctrl_q == ($past(AVS_WRITEDATA) & std_pkg::STD_WR_MASK))
      else $error("plain write did not land");

   stray_wr_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R12]
      CE && AVS_WRITE && !hit |=> ctrl_q == $past(ctrl_q))
      else $error("unmapped write changed control");

   rsvd_rd_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R12]
      rd_load_s |=> (AVS_READDATA & ~RD_MASK) == 32'h0000_0000)
      else $error("reserved bit read as one");

   rfs_rd_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R5]
      rd_load_s |=> !hit || AVS_READDATA[std_pkg::STD_BIT_RFS] == $past(rf_s))
      else $error("reference flag read mismatch");

   evt_rd_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R7]
      rd_load_s |=> !hit || AVS_READDATA[std_pkg::STD_BIT_EVT] == $past(evt_q))
      else $error("event flag read mismatch");

   evt_off_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R1]
      CE && !running |=> !evt_q)
      else $error("event active while disabled");

   fall_dir_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R3]
      CE && running && !ctrl_q[std_pkg::STD_BIT_DIR] && !cmp_s |=> evt_q)
      else $error("falling direction event missed");

   irq_once_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R8]
      CE && evt_q |=> !DETECT_IRQ)
      else $error("interrupt flag repeated during event");

   level_fwd_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R10]
      CE |=> ANA_CTL.level == $past(ctrl_q[std_pkg::STD_LVL_LSB +: std_pkg::STD_LVL_W]))
      else $error("trip code not forwarded");

   enable_fwd_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R2]
      CE |=> ANA_CTL.enable == $past(running))
      else $error("analog enable wrong");

   reset_val_a: assert property (@(posedge CLK) // [R13]
      SYS_RST |=> ctrl_q == std_pkg::STD_CTRL_RST && !DETECT_IRQ && !ANA_CTL.enable)
      else $error("reset value wrong");

   // the two-edge lag is only defined once reset has been gone for two edges
   sync_lag_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R16]
      $past(CE) && $past(CE, 2) && !$past(SYS_RST) && !$past(SYS_RST, 2)
      |-> cmp_s == $past(ANA_IN.cmp_above, 2))
      else $error("comparator synchroniser lag wrong");


   off_no_irq_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R1]
      !$past(running) && !running |-> !DETECT_IRQ)
      else $error("interrupt flag while detector disabled");
   idle_halt_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R2]
      CE && IDLE_MODE && ctrl_q[std_pkg::STD_BIT_IDLE] |=> !evt_q)
      else $error("event active while halted in idle");
   dir_sel_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R3]
      CE && running && ctrl_q[std_pkg::STD_BIT_DIR] && cmp_s |=> evt_q)
      else $error("rising direction event missed");
   bgs_rd_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R4]
      CE && AVS_READ && AVS_WAITREQUEST && !ack_q && hit
      |=> AVS_READDATA[std_pkg::STD_BIT_BGS] == $past(bg_s))
      else $error("band-gap flag read mismatch");
   ref_gate_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R5]
      CE && !rf_s |=> !DETECT_IRQ)
      else $error("interrupt flag with unstable reference");
   irq_pulse_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R8]
      enter_evt_s |=> DETECT_IRQ ##1 !DETECT_IRQ || !CE)
      else $error("interrupt flag not a single pulse");
   ext_sel_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R9]
      CE |=> ANA_CTL.ext_sel == ($past(ctrl_q[3:0]) == std_pkg::STD_LVL_EXT))
      else $error("external sense select wrong");
   rsvd_zero_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R12]
      (ctrl_q & ~std_pkg::STD_WR_MASK) == 32'h0000_0000)
      else $error("reserved bit stored");
   clr_alias_a: assert property (@(posedge CLK) disable iff (SYS_RST) // [R14]
      CE && AVS_WRITE && !AVS_WAITREQUEST && hit && op_of(AVS_ADDRESS) == std_pkg::STD_OP_CLR
      && AVS_WRITEDATA[15] && AVS_BYTEENABLE[1] |=> !ctrl_q[15])
      else $error("clear alias failed");
endmodule

// file: verif/std_ana_model.sv
// behavioural comparator and reference model for the detector bench
`timescale 1ns/100ps
module std_ana_model
#(
   parameter int SETTLE = 30
)
(
   // clock
   input wire logic CLK,
   // control from the block and bench stimulus in millivolts
   input wire std_pkg::std_ctl_t ctl,
   input var int sup_mv,
   input var int ext_mv,
   // raw levels back to the block
   output std_pkg::std_ana_t ana
);
   localparam int TRIP [5:14] = '{3440, 3130, 2920, 2820, 2630, 2520, 2400, 2300, 2210, 2110};
   int cnt = 0;
   // the reference restarts on each enable, so early trips must be masked by the block
   always @(posedge CLK)
      cnt <= ctl.enable ? (cnt < SETTLE ? cnt + 1 : cnt) : 0;
   always_comb
   begin
      ana.bg_stable = cnt >= SETTLE / 2;
      ana.ref_stable = cnt >= SETTLE;
      // comparator keeps running while disabled; gating is the block's job
      ana.cmp_above = ctl.ext_sel ? ext_mv >= 1200 : sup_mv >= TRIP[ctl.level];
   end
endmodule

// file: verif/std_top_tb.sv
// self-checking bench for the supply threshold detector control
`timescale 1ns/100ps
module std_top_tb;
   logic CLK = 0;
   logic SYS_RST = 1;
   logic [15:0] addr = 16'h0;
   logic rd = 0;
   logic wr = 0;
   logic [31:0] wdat = 32'h0;
   logic [31:0] rdat;
   logic wq;
   logic idle = 0;
   logic irq;
   logic [31:0] q;
   std_pkg::std_ana_t ana;
   std_pkg::std_ctl_t ctl;
   int sup_mv = 3300;
   int ext_mv = 0;
   int failures = 0;
   int checked = 0;
   int irqs = 0;
   std_top uut (.CLK(CLK), .SYS_RST(SYS_RST), .CE(1'b1), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wq), .IDLE_MODE(idle), .ANA_IN(ana), .ANA_CTL(ctl), .DETECT_IRQ(irq));
   std_ana_model model (.CLK(CLK), .ctl(ctl), .sup_mv(sup_mv), .ext_mv(ext_mv), .ana(ana));
   initial
      forever #4 CLK = ~CLK;
   always @(posedge CLK)
      if (irq === 1'b1)
         irqs <= irqs + 1;
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // one bus cycle held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK);
      wr <= w;
      rd <= !w;
      addr <= a;
      wdat <= d;
      do
      begin
         @(posedge CLK);
         n++;
      end
      while (wq !== 1'b0 && n < 40);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (wq !== 1'b0)
      begin
         failures++;
         summarize();
      end
   endtask
   // counts pulses over a window; a level would count several
   task automatic irq_in(input int n, input int exp);
      int c0;
      c0 = irqs;
      repeat (n) @(posedge CLK);
      check("irq count", 32'(irqs - c0), 32'(exp));
   endtask
   task automatic t_reset;
      bus(0, 16'h2310, 0);
      check("ctrl reset", q, 32'h0);
      check("ctl reset", 32'(ctl), 32'h0);
      bus(1, 16'h2400, 32'hffff_ffff);
      bus(0, 16'h2400, 0);
      check("unmapped", q, 32'h0);
      bus(0, 16'h2310, 0);
      check("ctrl after stray", q, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_fields;
      bus(1, 16'h2310, 32'hffff_ffff);
      bus(0, 16'h2310, 0);
      check("ctrl ones", q & 32'hffff_f8ff, 32'h0000_a80f);
      check("ctl ext", 32'(ctl), 32'h3f);
      bus(1, 16'h2314, 32'h0000_8800);
      bus(1, 16'h231c, 32'h0000_0003);
      bus(1, 16'h2318, 32'h0000_0800);
      repeat (6) @(posedge CLK);
      bus(0, 16'h2310, 0);
      check("alias result", q, 32'h0000_280c);
      check("ctl level", 32'(ctl), 32'h0c);
      $display("field test done");
   endtask
   task automatic t_event;
      bus(1, 16'h2310, 32'h0000_8008);
      repeat (40) @(posedge CLK); // reference settles before events are expected
      bus(0, 16'h2310, 0);
      check("stable idle", q, 32'h0000_8608);
      @(posedge CLK);
      // strictly below the trip: the model comparator reads an exact tie as above
      sup_mv <= 2800;
      irq_in(8, 1);
      bus(0, 16'h2310, 0);
      check("event on", q, 32'h0000_8708);
      sup_mv <= 3300;
      irq_in(8, 0);
      bus(0, 16'h2310, 0);
      check("event off", q, 32'h0000_8608);
      bus(1, 16'h2318, 32'h0000_0800);
      irq_in(8, 1);
      bus(1, 16'h2314, 32'h0000_0800);
      $display("event test done");
   endtask
   task automatic t_gate;
      bus(1, 16'h2314, 32'h0000_8000);
      sup_mv <= 2000;
      irq_in(10, 0);
      bus(1, 16'h2318, 32'h0000_8000);
      irq_in(12, 0);
      repeat (30) @(posedge CLK);
      sup_mv <= 3300;
      idle <= 1'b1;
      bus(1, 16'h2318, 32'h0000_2000);
      sup_mv <= 2000;
      irq_in(10, 0);
      check("halted enable", 32'(ctl.enable), 32'h0);
      sup_mv <= 3300;
      bus(1, 16'h2314, 32'h0000_2000);
      // leaving the halt restarts the reference, so let it settle first
      repeat (40) @(posedge CLK);
      sup_mv <= 2000;
      irq_in(10, 1);
      idle <= 1'b0;
      $display("gate test done");
   endtask
   initial
   begin
      repeat (5) @(posedge CLK);
      SYS_RST <= 1'b0;
      t_reset();
      t_fields();
      t_event();
      t_gate();
      summarize();
   end
endmodule
